/* link_peer.sv */
// External frame and bit clock master model
`timescale 1ns/1ps
`default_nettype none
module link_peer (
  input  wire  tx_data_pin_q,
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic rx_data_pin,
  output logic rate_gen_source_clock
);
  initial begin
    tx_bit_clock = 1'b0;
    tx_frame_sync = 1'b0;
    rx_bit_clock = 1'b0;
    rx_frame_sync = 1'b0;
    rx_data_pin = 1'b0;
  end
  // Source oscillator runs free, offset from the system clock edges
  initial begin
    rate_gen_source_clock = 1'b0;
    #5;
    forever #40 rate_gen_source_clock = ~rate_gen_source_clock;
  end
  // Bit clocks run only inside frames; both come from this side
  task frame(input int nb, input logic [31:0] rw, output logic [31:0] got);
    int i;
    begin
      got = 32'h0;
      #3;
      tx_frame_sync = 1'b1;
      rx_frame_sync = 1'b1;
      for (i = 0; i < nb; i++) begin
        rx_data_pin = rw[31 - i];
        #64;
        tx_bit_clock = 1'b1;
        rx_bit_clock = 1'b1;
        got = {got[30:0], tx_data_pin_q};
        tx_frame_sync = 1'b0;
        rx_frame_sync = 1'b0;
        #64;
        tx_bit_clock = 1'b0;
        rx_bit_clock = 1'b0;
      end
      // Released line must not keep the last bit
      rx_data_pin = ~rx_data_pin;
    end
  endtask
endmodule // link_peer
`default_nettype wire

/* rate_gen.v */
// Sample rate generator: divides a selected source into a bit clock enable
`timescale 1ns/1ps
`default_nettype none
`include "sport_defines.vh"

module rate_gen (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       run,
  input  wire       src_sel,
  input  wire       ext_src_rise,
  input  wire [7:0] divider,
  output reg        bit_clk_q,
  output reg        bit_rise_q
);

  reg  [7:0] cnt_q;
  reg        started_q;
  wire       src_tick;
  wire [8:0] period;
  wire [7:0] half;
  wire [7:0] cnt_inc;

  // Source 0 is the system clock, source 1 the synchronised external source
  assign src_tick = src_sel ? ext_src_rise : 1'b1;
  // One period is divider plus one ticks; a divider of zero leaves the clock high
  assign period  = {1'b0, divider} + 9'h001;
  assign half    = period[8:1];
  assign cnt_inc = cnt_q + 8'h01;

  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q      <= 8'h00;
      started_q  <= 1'b0;
      bit_clk_q  <= 1'b0;
      bit_rise_q <= 1'b0;
    end else begin
      bit_rise_q <= 1'b0;
      if (src_tick) begin
        if (!started_q) begin
          // First source edge after start drives the bit clock high
          started_q  <= 1'b1;
          bit_clk_q  <= 1'b1;
          bit_rise_q <= 1'b1;
          cnt_q      <= 8'h00;
        end else if (cnt_q == divider) begin
          cnt_q      <= 8'h00;
          bit_clk_q  <= 1'b1;
          bit_rise_q <= 1'b1;
        end else begin
          cnt_q <= cnt_inc;
          if (cnt_inc == half)
            bit_clk_q <= 1'b0;
        end
      end
    end
  end

endmodule // rate_gen

`default_nettype wire

/* serial_port_tx_startup_ext_frame_bench.sv */
// Self-checking bench for the serial port start-up block
`timescale 1ns/1ps
`default_nettype none
`include "sport_defines.vh"
module serial_port_tx_startup_ext_frame_bench;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, w, got;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync, rx_data_pin;
  logic        rate_gen_source_clock, tx_data_pin_q, generated_bit_clock_q;
  logic        pin_function_select_q, tx_dma_request_q, rx_dma_request_q, irq_q;
  int          fails, check_count, a, b, k, d;
  always #4 aclk = ~aclk;
  sport_startup DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_bit_clock, .tx_frame_sync, .rx_bit_clock,
    .rx_frame_sync, .rx_data_pin, .rate_gen_source_clock, .tx_data_pin_q,
    .generated_bit_clock_q, .pin_function_select_q, .tx_dma_request_q, .rx_dma_request_q,
    .irq_q);
  link_peer peer (.tx_data_pin_q, .tx_bit_clock, .tx_frame_sync, .rx_bit_clock,
    .rx_frame_sync, .rx_data_pin, .rate_gen_source_clock);
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      check_count++;
      if (e !== g) begin
        fails++;
        $display("FAIL %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task hung;
    begin
      fails++;
      give_verdict();
    end
  endtask
  // Places above 0x1C answer with an error, everything else with okay
  function automatic logic [1:0] resp_of(input logic [7:0] ad);
    resp_of = (ad > 8'h1C) ? `RESP_SLVERR : `RESP_OKAY;
  endfunction
  task wr(input logic [7:0] ad, input logic [31:0] dat);
    int n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 200; n++) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) break;
      end
      if (n == 200) hung();
      s_axi_bready <= 1'b0;
      chk("bresp", resp_of(ad), s_axi_bresp);
    end
  endtask
  task rd(input logic [7:0] ad, output logic [31:0] dat);
    int n;
    begin
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 200; n++) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && s_axi_rready) break;
      end
      if (n == 200) hung();
      dat = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk("rresp", resp_of(ad), s_axi_rresp);
    end
  endtask
  task wt(input logic lvl, output int n);
    begin
      for (n = 0; n < 400; n++) begin
        @(posedge aclk);
        if (generated_bit_clock_q === lvl) break;
      end
      if (n == 400) hung();
    end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    check_count = 0;
    k = $urandom(8);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_CTRL, v);
    chk("ctrl reset", 32'h0, v);
    rd(`OFF_RATE_GEN, v);
    chk("rate reset", 32'h1, v);
    rd(8'h20, v);
    wr(8'h24, 32'hFFFFFFFF);
    rd(`OFF_STATUS, v);
    chk("first fs early", 32'h0, v & 32'h8);
    wr(`OFF_CTRL, 32'hA2);
    wr(`OFF_CTRL, 32'hA0);
    repeat (32) @(posedge aclk);
    rd(`OFF_STATUS, v);
    chk("sync err flushed", 32'h0, v & 32'h4);
    wr(`OFF_IRQ_ENABLE, 32'h8);
    peer.frame(32, $urandom, got);
    repeat (8) @(posedge aclk);
    rd(`OFF_STATUS, v);
    chk("first fs flag", 32'h8, v & 32'h8);
    chk("first fs irq", 32'h1, {31'h0, irq_q});
    rd(`OFF_IRQ_STATUS, v);
    chk("fs irq in reset", 32'h0, v & 32'h3);
    chk("dma in reset", 32'h0, {30'h0, tx_dma_request_q, rx_dma_request_q});
    wr(`OFF_IRQ_CLEAR, 32'hF);
    repeat (4) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq_q});
    wr(`OFF_CTRL, 32'hA3);
    wr(`OFF_CTRL, 32'h1A3);
    wr(`OFF_IRQ_ENABLE, 32'h3);
    repeat (4) @(posedge aclk);
    chk("pin function", 32'h1, {31'h0, pin_function_select_q});
    chk("tx request", 32'h1, {31'h0, tx_dma_request_q});
    w = $urandom;
    peer.frame(32, w, got);
    chk("default word", `SHIFT_RESET, got);
    repeat (8) @(posedge aclk);
    rd(`OFF_IRQ_STATUS, v);
    chk("fs irq running", 32'h3, v & 32'h3);
    chk("irq line", 32'h1, {31'h0, irq_q});
    chk("rx request", 32'h1, {31'h0, rx_dma_request_q});
    wr(`OFF_IRQ_ENABLE, 32'h0);
    repeat (4) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq_q});
    wr(`OFF_IRQ_CLEAR, 32'hF);
    rd(`OFF_RX_DATA, v);
    chk("rx word", w, v);
    repeat (4) @(posedge aclk);
    chk("rx request gone", 32'h0, {31'h0, rx_dma_request_q});
    w = $urandom;
    rd(`OFF_STATUS, v);
    chk("tx ready", 32'h1, v & 32'h1);
    wr(`OFF_TX_HOLD, w);
    repeat (4) @(posedge aclk);
    chk("tx request gone", 32'h0, {31'h0, tx_dma_request_q});
    peer.frame(32, $urandom, got);
    chk("sent word", w, got);
    peer.frame(10, $urandom, got);
    peer.frame(32, $urandom, got);
    repeat (8) @(posedge aclk);
    rd(`OFF_STATUS, v);
    chk("mid word sync", 32'h4, v & 32'h4);
    wr(`OFF_CTRL, 32'h1A1);
    rd(`OFF_STATUS, v);
    chk("sync err cleared", 32'h0, v & 32'h4);
    for (k = 0; k < 3; k++) begin
      d = ($urandom % 3) * 2 + 1;
      wr(`OFF_CTRL, 32'h100);
      wr(`OFF_RATE_GEN, 32'h100 | d);
      wr(`OFF_CTRL, 32'h104);
      wt(1'b1, a);
      chk("gen start", 32'h1, (a < 20) ? 32'h1 : 32'h0);
      wt(1'b0, a);
      wt(1'b1, b);
      chk("gen period", 10 * (d + 1), a + b + 2);
    end
    wr(`OFF_CTRL, 32'h100);
    // Mid-run reset re-arms the first-enable error window
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_STATUS, v);
    chk("status after reset", 32'h0, v);
    wr(`OFF_CTRL, 32'h2);
    peer.frame(2, $urandom, got);
    rd(`OFF_STATUS, v);
    chk("spurious sync err", 32'hC, v & 32'hC);
    wr(`OFF_CTRL, 32'h0);
    rd(`OFF_STATUS, v);
    chk("spurious err flushed", 32'h0, v & 32'h4);
    give_verdict();
  end
endmodule // serial_port_tx_startup_ext_frame_bench
`default_nettype wire

/* sport_checker.sv */
// Port-level assertions for the serial port start-up block
`timescale 1ns/1ps
`default_nettype none
`include "sport_defines.vh"
module sport_checker (
  input wire       aclk,
  input wire       aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       tx_bit_clock,
  input wire       tx_frame_sync,
  input wire       rx_frame_sync,
  input wire       rate_gen_source_clock,
  input wire       tx_data_pin_q,
  input wire       generated_bit_clock_q,
  input wire       tx_dma_request_q,
  input wire       rx_dma_request_q,
  input wire       irq_q
);
  reg [3:0] tcnt_q;
  reg [3:0] scnt_q;
  reg [1:0] tprev_q;
  reg       sprev_q;
  // Cycles since link pin activity; saturates so long idles stay cheap
  always @(posedge aclk) begin
    tprev_q <= {tx_bit_clock, tx_frame_sync};
    sprev_q <= rate_gen_source_clock;
    if (!aresetn) begin
      tcnt_q <= 4'hF;
      scnt_q <= 4'hF;
    end else begin
      if (tprev_q != {tx_bit_clock, tx_frame_sync}) tcnt_q <= 4'h0;
      else if (tcnt_q != 4'hF) tcnt_q <= tcnt_q + 4'h1;
      if (rate_gen_source_clock && !sprev_q) scnt_q <= 4'h0;
      else if (scnt_q != 4'hF) scnt_q <= scnt_q + 4'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pin_quiet: assert property (
    $changed(tx_data_pin_q) |-> tcnt_q < 4'h8 || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("serial data moved without link activity");
  chk_gen_edge: assert property (
    $changed(generated_bit_clock_q) |-> scnt_q < 4'h8 || $past(s_axi_bvalid, 2))
    else $error("bit clock moved off a source edge");
  chk_rx_dma_drop: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_RX_DATA |-> ##[1:3] !rx_dma_request_q)
    else $error("rx request kept after data read");
  chk_tx_dma_drop: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OFF_TX_HOLD |-> ##[1:4] !tx_dma_request_q)
    else $error("tx request kept after holding write");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !irq_q && !tx_dma_request_q && !rx_dma_request_q)
    else $error("event output active in reset");
  chk_irq_clear: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !tx_frame_sync
    && !rx_frame_sync && s_axi_awaddr == `OFF_IRQ_CLEAR && s_axi_wdata[3:0] == 4'hF
    |-> ##[2:4] !irq_q) else $error("interrupt kept after full clear");
  chk_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1F
    |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR) else $error("unmapped read not refused");
  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped early");
  cover property ($rose(irq_q));
  cover property ($rose(tx_dma_request_q));
  cover property ($rose(rx_dma_request_q));
  cover property ($rose(generated_bit_clock_q));
endmodule // sport_checker
bind sport_startup sport_checker chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .tx_bit_clock, .tx_frame_sync, .rx_frame_sync, .rate_gen_source_clock,
  .tx_data_pin_q, .generated_bit_clock_q, .tx_dma_request_q, .rx_dma_request_q, .irq_q);
`default_nettype wire

/* sport_defines.vh */
// Register offsets, field positions and constants for the serial port start-up block
`ifndef SPORT_DEFINES_VH
`define SPORT_DEFINES_VH

`define OFF_CTRL        8'h00
`define OFF_RATE_GEN    8'h04
`define OFF_TX_HOLD     8'h08
`define OFF_RX_DATA     8'h0C
`define OFF_STATUS      8'h10
`define OFF_IRQ_STATUS  8'h14
`define OFF_IRQ_ENABLE  8'h18
`define OFF_IRQ_CLEAR   8'h1C

// Control register fields
`define CTRL_RX_RUN     0
`define CTRL_TX_RUN     1
`define CTRL_RG_RUN     2
`define CTRL_FG_RUN     3
`define CTRL_RX_SEL_LO  4
`define CTRL_RX_SEL_HI  5
`define CTRL_TX_SEL_LO  6
`define CTRL_TX_SEL_HI  7
`define CTRL_PIN_FUNC   8
`define CTRL_WIDTH      9
`define CTRL_RESET      9'h000

// Rate generator register fields
`define RG_DIV_LO       0
`define RG_DIV_HI       7
`define RG_SRC_SEL      8
`define RG_WIDTH        9
`define RG_RESET        9'h001

// Interrupt select encodings
`define SEL_READY       2'h0
`define SEL_FRAME_SYNC  2'h2

// Status bits
`define ST_TX_READY     0
`define ST_RX_READY     1
`define ST_TX_SYNC_ERR  2
`define ST_FIRST_FS     3

// Sticky event bits
`define EV_TX_IRQ       0
`define EV_RX_IRQ       1
`define EV_SYNC_ERR     2
`define EV_FIRST_FS     3
`define EV_WIDTH        4

`define WORD_BITS       32
`define BIT_CNT_W       5
`define BIT_CNT_LAST    5'h1F
`define SHIFT_RESET     32'h00000000
`define SYNC_ERR_WIN    2'h2

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* sport_startup.v */
// Serial port transmit/receive start-up core with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sport_defines.vh"

module sport_startup (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        tx_bit_clock,
  input  wire        tx_frame_sync,
  input  wire        rx_bit_clock,
  input  wire        rx_frame_sync,
  input  wire        rx_data_pin,
  input  wire        rate_gen_source_clock,
  output reg         tx_data_pin_q,
  output reg         generated_bit_clock_q,
  output reg         pin_function_select_q,
  output reg         tx_dma_request_q,
  output reg         rx_dma_request_q,
  output reg         irq_q
);

  // Two-flop synchronisers for all pin inputs
  reg [4:0] meta_q;
  reg [4:0] sync_q;
  reg [4:0] prev_q;
  wire [4:0] pins = {rate_gen_source_clock, rx_frame_sync, rx_bit_clock,
                     tx_frame_sync, tx_bit_clock};
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  wire [4:0] rise = sync_q & ~prev_q;
  reg  rx_d_meta_q;
  reg  rx_d_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_d_meta_q <= 1'b0;
      rx_d_q      <= 1'b0;
    end else begin
      rx_d_meta_q <= rx_data_pin;
      rx_d_q      <= rx_d_meta_q;
    end
  end

  // Registers
  reg [`CTRL_WIDTH-1:0] ctrl_q;
  reg [`RG_WIDTH-1:0]   rg_q;
  reg [31:0]            tx_hold_q;
  reg [31:0]            rx_data_q;
  reg [`EV_WIDTH-1:0]   ev_q;
  reg [`EV_WIDTH-1:0]   ev_en_q;

  wire rx_run = ctrl_q[`CTRL_RX_RUN];
  wire tx_run = ctrl_q[`CTRL_TX_RUN];
  wire [1:0] tx_sel = ctrl_q[`CTRL_TX_SEL_HI:`CTRL_TX_SEL_LO];
  wire [1:0] rx_sel = ctrl_q[`CTRL_RX_SEL_HI:`CTRL_RX_SEL_LO];

  // Rate generator
  wire gen_clk;
  wire gen_rise;
  rate_gen u_rate_gen (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .run          (ctrl_q[`CTRL_RG_RUN]),
    .src_sel      (rg_q[`RG_SRC_SEL]),
    .ext_src_rise (rise[4]),
    .divider      (rg_q[`RG_DIV_HI:`RG_DIV_LO]),
    .bit_clk_q    (gen_clk),
    .bit_rise_q   (gen_rise)
  );

  // Transmitter
  reg        tx_hold_full_q;
  reg        tx_active_q;
  reg [31:0] tx_shift_reg_q;
  reg [4:0]  tx_cnt_q;
  reg        tx_first_q;
  reg        tx_ever_q;
  reg [1:0]  tx_win_q;
  reg        tx_err_q;
  reg        tx_copy;
  wire       tx_fs = rise[1];
  wire       tx_bit = rise[0];
  wire       wr_hold;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_active_q    <= 1'b0;
      tx_shift_reg_q <= `SHIFT_RESET;
      tx_cnt_q       <= 5'h00;
      tx_first_q     <= 1'b0;
      tx_ever_q      <= 1'b0;
      tx_win_q       <= 2'h0;
      tx_err_q       <= 1'b0;
      tx_data_pin_q  <= 1'b0;
    end else if (!tx_run) begin
      tx_active_q <= 1'b0;
      tx_cnt_q    <= 5'h00;
      tx_win_q    <= 2'h0;
      tx_first_q  <= 1'b0;
      tx_err_q    <= 1'b0;
    end else begin
      // Spurious sync error window on the very first enable
      if (!tx_ever_q) begin
        tx_ever_q  <= 1'b1;
        tx_first_q <= 1'b1;
      end
      if (tx_first_q && tx_bit) begin
        tx_win_q <= tx_win_q + 2'h1;
        if (tx_win_q + 2'h1 == `SYNC_ERR_WIN)
          tx_first_q <= 1'b0;
      end
      if (tx_first_q && tx_fs)
        tx_err_q <= 1'b1;
      if (tx_fs && tx_active_q && tx_cnt_q != 5'h00)
        tx_err_q <= 1'b1;
      // Shifting starts only on an external frame sync
      if (tx_fs) begin
        tx_active_q <= 1'b1;
        tx_cnt_q    <= `BIT_CNT_LAST;
        // Empty holding register leaves the shift register content in place
        if (tx_hold_full_q)
          tx_shift_reg_q <= tx_hold_q;
        tx_data_pin_q <= tx_hold_full_q ? tx_hold_q[31] : tx_shift_reg_q[31];
      end else if (tx_active_q && tx_bit) begin
        tx_shift_reg_q <= {tx_shift_reg_q[30:0], 1'b0};
        tx_data_pin_q  <= tx_shift_reg_q[30];
        tx_cnt_q       <= tx_cnt_q - 5'h01;
        if (tx_cnt_q == 5'h00)
          tx_active_q <= 1'b0;
      end
    end
  end

  always @* begin
    tx_copy = tx_run && tx_fs && tx_hold_full_q;
  end

  always @(posedge aclk) begin
    if (!aresetn || !tx_run)
      tx_hold_full_q <= 1'b0;
    else if (wr_hold)
      tx_hold_full_q <= 1'b1;
    else if (tx_copy)
      tx_hold_full_q <= 1'b0;
  end

  // Receiver
  reg [31:0] rx_shift_q;
  reg [4:0]  rx_cnt_q;
  reg        rx_active_q;
  reg        rx_full_q;
  wire       rd_rx;
  wire       rx_fs = rise[3];
  wire       rx_done = rx_active_q && rise[2] && rx_cnt_q == 5'h00;
  always @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_shift_q  <= `SHIFT_RESET;
      rx_cnt_q    <= 5'h00;
      rx_active_q <= 1'b0;
      rx_full_q   <= 1'b0;
      rx_data_q   <= `SHIFT_RESET;
    end else begin
      if (rx_fs) begin
        rx_active_q <= 1'b1;
        rx_cnt_q    <= `BIT_CNT_LAST;
      end else if (rx_active_q && rise[2]) begin
        rx_shift_q <= {rx_shift_q[30:0], rx_d_q};
        rx_cnt_q   <= rx_cnt_q - 5'h01;
        if (rx_cnt_q == 5'h00)
          rx_active_q <= 1'b0;
      end
      if (rx_done) begin
        rx_data_q <= {rx_shift_q[30:0], rx_d_q};
        rx_full_q <= 1'b1;
      end else if (rd_rx)
        rx_full_q <= 1'b0;
    end
  end

  // First frame sync seen locally, usable while sections are still held
  reg first_fs_q;
  always @(posedge aclk) begin
    if (!aresetn)
      first_fs_q <= 1'b0;
    else if (tx_fs || rx_fs)
      first_fs_q <= 1'b1;
  end

  wire tx_ready = tx_run && !tx_hold_full_q;
  wire rx_ready = rx_run && rx_full_q;

  // Interrupt source selection per section
  function irq_src;
    input [1:0] sel;
    input       run;
    input       ready;
    input       fs;
    begin
      if (!run)
        irq_src = 1'b0;
      else if (sel == `SEL_FRAME_SYNC)
        irq_src = fs;
      else
        irq_src = ready;
    end
  endfunction

  wire [`EV_WIDTH-1:0] ev_set;
  assign ev_set[`EV_TX_IRQ]   = irq_src(tx_sel, tx_run, tx_ready, tx_fs);
  assign ev_set[`EV_RX_IRQ]   = irq_src(rx_sel, rx_run, rx_done, rx_fs);
  assign ev_set[`EV_SYNC_ERR] = tx_err_q;
  assign ev_set[`EV_FIRST_FS] = (tx_fs || rx_fs) && !first_fs_q;

  // AXI4-Lite slave
  reg [7:0]  aw_q;
  reg        aw_have_q;
  reg [31:0] w_q;
  reg [3:0]  ws_q;
  reg        w_have_q;
  wire       do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire       wr_hit_ctrl = do_wr && aw_q == `OFF_CTRL;
  assign wr_hold = do_wr && aw_q == `OFF_TX_HOLD;
  wire       wr_clr = do_wr && aw_q == `OFF_IRQ_CLEAR && ws_q[0];
  assign rd_rx = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_RX_DATA;

  function known;
    input [7:0] a;
    begin
      known = a == `OFF_CTRL || a == `OFF_RATE_GEN || a == `OFF_TX_HOLD ||
              a == `OFF_RX_DATA || a == `OFF_STATUS || a == `OFF_IRQ_STATUS ||
              a == `OFF_IRQ_ENABLE || a == `OFF_IRQ_CLEAR;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 8'h00;
      aw_have_q     <= 1'b0;
      w_q           <= 32'h00000000;
      ws_q          <= 4'h0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      ctrl_q        <= `CTRL_RESET;
      rg_q          <= `RG_RESET;
      tx_hold_q     <= `SHIFT_RESET;
      ev_en_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q          <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q          <= s_axi_wdata;
        ws_q         <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(aw_q) ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_hit_ctrl) begin
          if (ws_q[0])
            ctrl_q[7:0] <= w_q[7:0];
          if (ws_q[1])
            ctrl_q[`CTRL_PIN_FUNC] <= w_q[`CTRL_PIN_FUNC];
        end
        if (aw_q == `OFF_RATE_GEN) begin
          if (ws_q[0])
            rg_q[7:0] <= w_q[7:0];
          if (ws_q[1])
            rg_q[`RG_SRC_SEL] <= w_q[`RG_SRC_SEL];
        end
        if (wr_hold)
          tx_hold_q <= w_q;
        if (aw_q == `OFF_IRQ_ENABLE && ws_q[0])
          ev_en_q <= w_q[`EV_WIDTH-1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Sticky events: a set in the same cycle as a clear wins
  always @(posedge aclk) begin
    if (!aresetn)
      ev_q <= 4'h0;
    else
      ev_q <= (ev_q & ~(wr_clr ? w_q[`EV_WIDTH-1:0] : 4'h0)) | ev_set;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFF_CTRL:       s_axi_rdata <= {23'h000000, ctrl_q};
        `OFF_RATE_GEN:   s_axi_rdata <= {23'h000000, rg_q};
        `OFF_RX_DATA:    s_axi_rdata <= rx_data_q;
        `OFF_STATUS:     s_axi_rdata <= {28'h0000000, first_fs_q, tx_err_q,
                                         rx_ready, tx_ready};
        `OFF_IRQ_STATUS: s_axi_rdata <= {28'h0000000, ev_q};
        `OFF_IRQ_ENABLE: s_axi_rdata <= {28'h0000000, ev_en_q};
        default:         s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Outputs, each from a flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      generated_bit_clock_q <= 1'b0;
      pin_function_select_q <= 1'b0;
      tx_dma_request_q      <= 1'b0;
      rx_dma_request_q      <= 1'b0;
      irq_q                 <= 1'b0;
    end else begin
      generated_bit_clock_q <= gen_clk && gen_rise | gen_clk;
      pin_function_select_q <= ctrl_q[`CTRL_PIN_FUNC];
      tx_dma_request_q      <= tx_ready && !wr_hold;
      rx_dma_request_q      <= rx_ready && !rd_rx;
      irq_q                 <= |(ev_q & ev_en_q);
    end
  end

endmodule // sport_startup

`default_nettype wire
